// ==== src/light_sensor_status_result_regs.sv ====
// i2c slave with the status, identification, result and gain registers
`timescale 1ns/1ps
module light_sensor_status_result_regs
	import light_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic conv_valid,
	input wire logic [15:0] vis_raw,
	input wire logic [15:0] ir_raw,
	input wire logic [15:0] thresh_low,
	input wire logic [15:0] thresh_high,
	input wire logic [3:0] persistence_setting,
	input wire logic [1:0] coarse_gain_field,
	input wire logic saturation_event,
	input wire logic calibration_done_event,
	output logic [7:0] event_flags,
	output logic gain_boost_bit,
	output logic gain_low_select_bit,
	output logic [8:0] overall_gain_x2
);
	light_result_if lr ();

	logic scl_meta, scl_s, scl_p, sda_meta, sda_s, sda_p;
	logic scl_rise, scl_fall, start_cond, stop_cond, last_rise, wr_stb, rd_stb;
	i2c_state_t state;
	logic [7:0] shreg, ptr, byte_in, rd_value, vis_high_hold, ir_high_hold;
	logic [2:0] bit_cnt;
	logic ack_phase, rw_read;
	logic [7:0] interrupt_behaviour_cfg, next_event_flags, flag_set, flag_clr;

	assign lr.conv_valid = conv_valid;
	assign lr.vis_raw = vis_raw;
	assign lr.ir_raw = ir_raw;
	assign lr.thresh_low = thresh_low;
	assign lr.thresh_high = thresh_high;
	assign lr.persistence = persistence_setting;

	light_event_tracker u_tracker (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.lr(lr)
	);

	// pins are asynchronous to sys_clk
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{scl_meta, scl_s, scl_p} <= 3'h7;
			{sda_meta, sda_s, sda_p} <= 3'h7;
		end
		else
		begin
			{scl_p, scl_s, scl_meta} <= {scl_s, scl_meta, scl_pin};
			{sda_p, sda_s, sda_meta} <= {sda_s, sda_meta, sda_pin_in};
		end
	end

	assign scl_rise = scl_s && !scl_p;
	assign scl_fall = !scl_s && scl_p;
	assign start_cond = scl_s && scl_p && sda_p && !sda_s;
	assign stop_cond = scl_s && scl_p && !sda_p && sda_s;
	assign byte_in = {shreg[6:0], sda_s};
	assign last_rise = scl_rise && (bit_cnt == 3'h7);
	assign wr_stb = (state == ST_WR) && last_rise;
	// a read byte is fetched on the fall that starts its first bit
	assign rd_stb = scl_fall && ack_phase
		&& (((state == ST_ADDR_ACK) && rw_read) || (state == ST_RD_ACK));

	// unmapped offsets read zero
	always_comb
	begin
		case (ptr)
			REVISION_OFS: rd_value = REVISION_VALUE;
			PART_TYPE_OFS: rd_value = PART_TYPE_VALUE;
			EVENT_FLAGS_OFS: rd_value = event_flags;
			VIS_LOW_OFS: rd_value = lr.vis_count[7:0];
			VIS_HIGH_OFS: rd_value = vis_high_hold;
			IR_LOW_OFS: rd_value = lr.ir_count[7:0];
			IR_HIGH_OFS: rd_value = ir_high_hold;
			AUX_REVISION_OFS: rd_value = AUX_REVISION_VALUE;
			GAIN_EXT_OFS: rd_value = {3'h0, gain_boost_bit, 1'b0, gain_low_select_bit, 2'h0};
			BEHAVIOUR_CFG_OFS: rd_value = interrupt_behaviour_cfg;
			default: rd_value = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_IDLE;
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			ack_phase <= 1'b0;
			rw_read <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (start_cond)
		begin
			state <= ST_ADDR;
			bit_cnt <= 3'h0;
			ack_phase <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (stop_cond)
		begin
			state <= ST_IDLE;
			ack_phase <= 1'b0;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (state)
				ST_ADDR, ST_PTR, ST_WR:
				begin
					if (scl_rise)
					begin
						shreg <= byte_in;
						bit_cnt <= bit_cnt + 3'h1;
					end
					if (last_rise)
					begin
						if (state == ST_PTR)
							state <= ST_PTR_ACK;
						else if (state == ST_WR)
							state <= ST_WR_ACK;
						else if (byte_in[7:1] == BUS_ADDRESS)
						begin
							state <= ST_ADDR_ACK;
							rw_read <= byte_in[0];
						end
						else
							state <= ST_IDLE;
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK:
				begin
					if (scl_fall && !ack_phase)
					begin
						sda_oe <= 1'b1;
						ack_phase <= 1'b1;
					end
					else if (scl_fall)
					begin
						ack_phase <= 1'b0;
						bit_cnt <= 3'h0;
						if ((state == ST_ADDR_ACK) && rw_read)
						begin
							state <= ST_RD;
							shreg <= rd_value;
							sda_oe <= !rd_value[7];
						end
						else
						begin
							state <= (state == ST_ADDR_ACK) ? ST_PTR : ST_WR;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_RD:
				begin
					if (scl_rise)
					begin
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7)
							state <= ST_RD_ACK;
					end
					if (scl_fall)
					begin
						shreg <= {shreg[6:0], 1'b0};
						sda_oe <= !shreg[6];
					end
				end
				ST_RD_ACK:
				begin
					if (scl_fall && !ack_phase)
						sda_oe <= 1'b0;
					else if (scl_fall)
					begin
						ack_phase <= 1'b0;
						bit_cnt <= 3'h0;
						state <= ST_RD;
						shreg <= rd_value;
						sda_oe <= !rd_value[7];
					end
					if (scl_rise)
					begin
						if (sda_s)
							state <= ST_IDLE;
						else
							ack_phase <= 1'b1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// pointer auto-increments after every written byte and as each read byte is fetched
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			ptr <= 8'h00;
		else if ((state == ST_PTR) && last_rise)
			ptr <= byte_in;
		else if (wr_stb || rd_stb)
			ptr <= ptr + 8'h01;
	end
	// open drain: the level driven is always low
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end
	// high bytes snap when the low byte goes out, so a pair never tears
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vis_high_hold <= 8'h00;
			ir_high_hold <= 8'h00;
		end
		else if (rd_stb)
		begin
			if (ptr == VIS_LOW_OFS)
				vis_high_hold <= lr.vis_count[15:8];
			if (ptr == IR_LOW_OFS)
				ir_high_hold <= lr.ir_count[15:8];
		end
	end

	// writes to read-only offsets fall through untouched
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gain_boost_bit <= BOOST_RESET;
			gain_low_select_bit <= LOW_SEL_RESET;
			interrupt_behaviour_cfg <= BEHAVIOUR_CFG_RESET;
		end
		else if (wr_stb)
		begin
			if (ptr == GAIN_EXT_OFS)
			begin
				gain_boost_bit <= byte_in[BOOST_BIT];
				gain_low_select_bit <= byte_in[LOW_SEL_BIT];
			end
			if (ptr == BEHAVIOUR_CFG_OFS)
				interrupt_behaviour_cfg <= byte_in;
		end
	end

	// undefined combinations still give a value, host must avoid them
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			overall_gain_x2 <= gain_times_two(2'h0, BOOST_RESET, LOW_SEL_RESET);
		else
			overall_gain_x2 <= gain_times_two(coarse_gain_field, gain_boost_bit,
				gain_low_select_bit);
	end

	always_comb
	begin
		flag_set = 8'h00;
		flag_set[SAT_FLAG_BIT] = saturation_event;
		flag_set[THRESH_FLAG_BIT] = lr.threshold_event;
		flag_set[CAL_FLAG_BIT] = calibration_done_event;
		flag_clr = 8'h00;
		if (wr_stb && (ptr == EVENT_FLAGS_OFS))
			flag_clr = byte_in;
		if (rd_stb && (ptr == EVENT_FLAGS_OFS) && interrupt_behaviour_cfg[CLEAR_ON_READ_BIT])
			flag_clr = 8'hFF;
		// a new event beats a clear in the same cycle
		next_event_flags = (event_flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			event_flags <= FLAGS_RESET;
		else
			event_flags <= next_event_flags;
	end
	sequence s_no_event;
		!saturation_event && !calibration_done_event && !lr.threshold_event;
	endsequence
	sequence s_cor_read;
		rd_stb && (ptr == EVENT_FLAGS_OFS) && interrupt_behaviour_cfg[CLEAR_ON_READ_BIT];
	endsequence
	property p_cor_clear;
		@(posedge sys_clk) disable iff (!arst_n)
		s_cor_read ##0 s_no_event |=> event_flags == 8'h00;
	endproperty
	a_cor_clear: assert property (p_cor_clear) else $error("read did not clear");
	property p_sat_set;
		@(posedge sys_clk) disable iff (!arst_n)
		saturation_event |=> event_flags[SAT_FLAG_BIT];
	endproperty
	a_sat_set: assert property (p_sat_set) else $error("saturation flag missed");
	property p_thresh_set;
		@(posedge sys_clk) disable iff (!arst_n)
		lr.threshold_event |=> event_flags[THRESH_FLAG_BIT];
	endproperty
	a_thresh_set: assert property (p_thresh_set) else $error("threshold flag missed");
	property p_cal_set;
		@(posedge sys_clk) disable iff (!arst_n)
		calibration_done_event |=> event_flags[CAL_FLAG_BIT];
	endproperty
	a_cal_set: assert property (p_cal_set) else $error("calibration flag missed");
	property p_w1c;
		@(posedge sys_clk) disable iff (!arst_n)
		wr_stb && (ptr == EVENT_FLAGS_OFS) && byte_in[SAT_FLAG_BIT] && !saturation_event
			|=> !event_flags[SAT_FLAG_BIT];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");
	property p_flag_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		event_flags[CAL_FLAG_BIT] && !wr_stb && !rd_stb |=> event_flags[CAL_FLAG_BIT];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
	property p_id_read;
		@(posedge sys_clk) disable iff (!arst_n)
		rd_stb && (ptr == REVISION_OFS) |=> shreg == REVISION_VALUE && state == ST_RD;
	endproperty
	a_id_read: assert property (p_id_read) else $error("revision value wrong");
	property p_type_read;
		@(posedge sys_clk) disable iff (!arst_n)
		rd_stb && (ptr == PART_TYPE_OFS || ptr == AUX_REVISION_OFS) |=> shreg != 8'h00
			&& (($past(ptr) == PART_TYPE_OFS) ? (shreg[1:0] == 2'h0) : (shreg[7:4] == 4'h0));
	endproperty
	a_type_read: assert property (p_type_read) else $error("id value wrong");
	property p_gain_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		!(wr_stb && ptr == GAIN_EXT_OFS) |=> $stable({gain_boost_bit, gain_low_select_bit});
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("gain bits moved");
	property p_gain_max;
		@(posedge sys_clk) disable iff (!arst_n)
		(coarse_gain_field == 2'h3 && gain_boost_bit && gain_low_select_bit)[*2]
			|-> overall_gain_x2 == 9'h100;
	endproperty
	a_gain_max: assert property (p_gain_max) else $error("gain 128x wrong");
	property p_gain_half;
		@(posedge sys_clk) disable iff (!arst_n)
		(coarse_gain_field == 2'h0 && !gain_boost_bit && !gain_low_select_bit)[*2]
			|-> overall_gain_x2 == 9'h001;
	endproperty
	a_gain_half: assert property (p_gain_half) else $error("gain 1/2x wrong");
	property p_pair;
		@(posedge sys_clk) disable iff (!arst_n)
		rd_stb && (ptr == VIS_LOW_OFS) |=> vis_high_hold == $past(lr.vis_count[15:8]);
	endproperty
	a_pair: assert property (p_pair) else $error("high byte not held");
	property p_idle_release;
		@(posedge sys_clk) disable iff (!arst_n)
		stop_cond |=> !sda_oe && state == ST_IDLE;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("sda held after stop");
endmodule

// ==== src/light_regs_pkg.sv ====
// constants, types and helpers for the light sensor status and result registers
package light_regs_pkg;
	// bus address is arbitrary, not taken from any part
	localparam logic [6:0] BUS_ADDRESS = 7'h2A;
	localparam logic [7:0] REVISION_OFS = 8'h91;
	localparam logic [7:0] PART_TYPE_OFS = 8'h92;
	localparam logic [7:0] EVENT_FLAGS_OFS = 8'h93;
	localparam logic [7:0] VIS_LOW_OFS = 8'h94;
	localparam logic [7:0] VIS_HIGH_OFS = 8'h95;
	localparam logic [7:0] IR_LOW_OFS = 8'h96;
	localparam logic [7:0] IR_HIGH_OFS = 8'h97;
	localparam logic [7:0] AUX_REVISION_OFS = 8'h9E;
	localparam logic [7:0] GAIN_EXT_OFS = 8'h9F;
	localparam logic [7:0] BEHAVIOUR_CFG_OFS = 8'hAB;
	// identification values are arbitrary
	localparam logic [7:0] REVISION_VALUE = 8'h02;
	localparam logic [7:0] PART_TYPE_VALUE = 8'h54;
	localparam logic [7:0] AUX_REVISION_VALUE = 8'h05;
	localparam int SAT_FLAG_BIT = 7;
	localparam int THRESH_FLAG_BIT = 4;
	localparam int CAL_FLAG_BIT = 3;
	localparam int BOOST_BIT = 4;
	localparam int LOW_SEL_BIT = 2;
	localparam int CLEAR_ON_READ_BIT = 7;
	localparam logic BOOST_RESET = 1'b0;
	localparam logic LOW_SEL_RESET = 1'b1;
	localparam logic [7:0] BEHAVIOUR_CFG_RESET = 8'h4C;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} i2c_state_t;

	function automatic logic [5:0] persist_target(input logic [3:0] p);
		case (p)
			4'h0: return 6'h00;
			4'h1: return 6'h01;
			4'h2: return 6'h02;
			4'h3: return 6'h03;
			4'h4: return 6'h05;
			default: return ({2'b00, p} - 6'h03) * 6'h05;
		endcase
	endfunction

	// gain in half steps: 1 means 1/2x, 256 means 128x
	function automatic logic [8:0] gain_times_two(input logic [1:0] coarse,
		input logic boost, input logic low_sel);
		logic [8:0] g;
		g = 9'h002 << {coarse, 1'b0};
		if (!low_sel)
			g = g >> 1;
		if (boost)
			g = g << 1;
		return g;
	endfunction
endpackage

// ==== src/light_result_if.sv ====
// bundle between the register core and the conversion tracker
`timescale 1ns/1ps
interface light_result_if;
	logic conv_valid;
	logic [15:0] vis_raw;
	logic [15:0] ir_raw;
	logic [15:0] thresh_low;
	logic [15:0] thresh_high;
	logic [3:0] persistence;
	logic [15:0] vis_count;
	logic [15:0] ir_count;
	logic threshold_event;

	modport tracker (input conv_valid, vis_raw, ir_raw, thresh_low, thresh_high, persistence,
		output vis_count, ir_count, threshold_event);
	modport core (output conv_valid, vis_raw, ir_raw, thresh_low, thresh_high, persistence,
		input vis_count, ir_count, threshold_event);
endinterface

// ==== src/light_event_tracker.sv ====
// result capture for both channels and persistence filter for the visible channel
`timescale 1ns/1ps
module light_event_tracker
	import light_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	light_result_if.tracker lr
);
	logic [5:0] run_len;
	logic [5:0] target;
	logic outside;

	assign outside = (lr.vis_raw < lr.thresh_low) || (lr.vis_raw > lr.thresh_high);
	assign target = persist_target(lr.persistence);

	// results only move on a finished conversion
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lr.vis_count <= 16'h0000;
			lr.ir_count <= 16'h0000;
		end
		else if (lr.conv_valid)
		begin
			lr.vis_count <= lr.vis_raw;
			lr.ir_count <= lr.ir_raw;
		end
	end

	// saturates so a long excursion cannot wrap into a false match
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			run_len <= 6'h00;
		else if (lr.conv_valid)
		begin
			if (!outside)
				run_len <= 6'h00;
			else if (run_len != 6'h3F)
				run_len <= run_len + 6'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			lr.threshold_event <= 1'b0;
		else
			lr.threshold_event <= lr.conv_valid && ((target == 6'h00)
				|| (outside && (run_len + 6'h01 == target)));
	end

	property p_run_clear;
		@(posedge sys_clk) disable iff (!arst_n)
		lr.conv_valid && !outside |=> run_len == 6'h00;
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("run length not cleared");

	property p_every_cycle;
		@(posedge sys_clk) disable iff (!arst_n)
		lr.conv_valid && target == 6'h00 |=> lr.threshold_event;
	endproperty
	a_every_cycle: assert property (p_every_cycle) else $error("persistence 0 missed");

	property p_no_event_inside;
		@(posedge sys_clk) disable iff (!arst_n)
		lr.conv_valid && !outside && target != 6'h00 |=> !lr.threshold_event;
	endproperty
	a_no_event_inside: assert property (p_no_event_inside) else $error("event inside");

	property p_capture;
		@(posedge sys_clk) disable iff (!arst_n)
		lr.conv_valid |=> lr.vis_count == $past(lr.vis_raw) && lr.ir_count == $past(lr.ir_raw);
	endproperty
	a_capture: assert property (p_capture) else $error("result not captured");
endmodule

// ==== sim/i2c_host_model.sv ====
// i2c host model: drives scl and pulls sda low, reads the open-drain wire
`timescale 1ns/1ps
module i2c_host_model
	import light_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// sda moves only in the low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		tick(2);
		sda_low <= !b;
		tick(6);
		scl <= 1'b1;
		tick(4);
		s = sda_wire;
		tick(4);
		scl <= 1'b0;
	endtask

	task automatic start();
		tick(2);
		sda_low <= 1'b0;
		tick(6);
		scl <= 1'b1;
		tick(8);
		sda_low <= 1'b1;
		tick(8);
		scl <= 1'b0;
	endtask

	task automatic stop();
		tick(2);
		sda_low <= 1'b1;
		tick(6);
		scl <= 1'b1;
		tick(8);
		sda_low <= 1'b0;
		tick(8);
	endtask

	// pull9 drives the ninth bit low: master ack on reads
	task automatic xfer(input logic [7:0] d, input logic pull9, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(!pull9, s);
		ack = !s;
	endtask

	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start();
		xfer({BUS_ADDRESS, 1'b0}, 1'b0, q, a0);
		xfer(ofs, 1'b0, q, a1);
		xfer(d, 1'b0, q, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask

	// n bytes from ofs upward, first byte in the low half
	task automatic read_reg(input logic [7:0] ofs, input int n, output logic [15:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, x;
		start();
		xfer({BUS_ADDRESS, 1'b0}, 1'b0, q, a0);
		xfer(ofs, 1'b0, q, a1);
		start();
		xfer({BUS_ADDRESS, 1'b1}, 1'b0, q, a2);
		d = 16'h0000;
		for (int i = 0; i < n; i++)
		begin
			xfer(8'hFF, i < n - 1, q, x);
			d[i * 8 +: 8] = q;
		end
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the light sensor register block
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin n_errors++; \
	$display("[FAIL] %0t %s", $time, msg); end end
module testbench
	import light_regs_pkg::*;
;
	logic sys_clk = 1'b0;
	logic arst_n, scl_pin, sda_low, sda_wire, sda_out, sda_oe, conv_valid, ok;
	logic saturation_event, calibration_done_event, gain_boost_bit, gain_low_select_bit;
	logic [15:0] vis_raw, ir_raw, thresh_low, thresh_high, rd;
	logic [3:0] persistence_setting;
	logic [1:0] coarse_gain_field;
	logic [7:0] event_flags;
	logic [8:0] overall_gain_x2;
	int n_errors = 0;
	int compares = 0;

	always #4 sys_clk = ~sys_clk;
	// pulled-up wire: low when either side pulls
	assign sda_wire = (sda_oe ? sda_out : 1'b1) & !sda_low;

	light_sensor_status_result_regs i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
		.scl_pin(scl_pin), .sda_pin_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
		.conv_valid(conv_valid), .vis_raw(vis_raw), .ir_raw(ir_raw),
		.thresh_low(thresh_low), .thresh_high(thresh_high),
		.persistence_setting(persistence_setting), .coarse_gain_field(coarse_gain_field),
		.saturation_event(saturation_event), .calibration_done_event(calibration_done_event),
		.event_flags(event_flags), .gain_boost_bit(gain_boost_bit),
		.gain_low_select_bit(gain_low_select_bit), .overall_gain_x2(overall_gain_x2));
	i2c_host_model i_host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl_pin),
		.sda_low(sda_low));

	task automatic rd_chk(input logic [7:0] ofs, input int n, input logic [15:0] exp,
		input string m);
		i_host.read_reg(ofs, n, rd, ok);
		`CHECK(ok, 1'b1, "read not acked")
		`CHECK(rd, exp, m)
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		i_host.write_reg(ofs, d, ok);
		`CHECK(ok, 1'b1, "write not acked")
	endtask

	task automatic conv(input logic [15:0] v, input logic [15:0] r);
		@(posedge sys_clk);
		vis_raw <= v;
		ir_raw <= r;
		conv_valid <= 1'b1;
		@(posedge sys_clk);
		conv_valid <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic ev(input logic sat, input logic cal);
		@(posedge sys_clk);
		saturation_event <= sat;
		calibration_done_event <= cal;
		@(posedge sys_clk);
		saturation_event <= 1'b0;
		calibration_done_event <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic t_reset();
		`CHECK(event_flags, 8'h00, "flags reset")
		`CHECK({gain_boost_bit, gain_low_select_bit}, 2'h1, "gain bits reset")
		`CHECK(overall_gain_x2, 9'h002, "gain reset")
		rd_chk(GAIN_EXT_OFS, 1, 16'h0004, "gain reg reset");
		rd_chk(BEHAVIOUR_CFG_OFS, 1, 16'h004C, "cfg reset");
		rd_chk(VIS_LOW_OFS, 2, 16'h0000, "vis reset");
		rd_chk(IR_LOW_OFS, 2, 16'h0000, "ir reset");
	endtask

	task automatic t_ids();
		wr(REVISION_OFS, 8'hFF);
		wr(PART_TYPE_OFS, 8'hFF);
		wr(AUX_REVISION_OFS, 8'hFF);
		wr(VIS_HIGH_OFS, 8'hFF);
		rd_chk(REVISION_OFS, 1, {8'h00, REVISION_VALUE}, "revision");
		rd_chk(PART_TYPE_OFS, 1, {8'h00, PART_TYPE_VALUE}, "part type");
		rd_chk(AUX_REVISION_OFS, 2, {8'h04, AUX_REVISION_VALUE}, "aux id");
		rd_chk(VIS_LOW_OFS, 2, 16'h0000, "vis after write");
		rd_chk(8'hA0, 1, 16'h0000, "unmapped");
	endtask

	task automatic t_flags();
		ev(1'b1, 1'b1);
		`CHECK(event_flags, 8'h88, "sat and cal set")
		rd_chk(EVENT_FLAGS_OFS, 1, 16'h0088, "flags read");
		`CHECK(event_flags, 8'h88, "flags held")
		wr(EVENT_FLAGS_OFS, 8'h80);
		`CHECK(event_flags, 8'h08, "clear bit 7 only")
		wr(EVENT_FLAGS_OFS, 8'h08);
		`CHECK(event_flags, 8'h00, "clear bit 3")
	endtask

	task automatic t_threshold();
		@(posedge sys_clk);
		thresh_low <= 16'h0064;
		thresh_high <= 16'h00C8;
		persistence_setting <= 4'h2;
		conv(16'h0032, 16'h0000);
		conv(16'h0096, 16'h0000);
		conv(16'h00FA, 16'h0000);
		`CHECK(event_flags[4], 1'b0, "run broken by inside result")
		conv(16'h012C, 16'h0000);
		`CHECK(event_flags[4], 1'b1, "two outside in a row")
		wr(EVENT_FLAGS_OFS, 8'h10);
		`CHECK(event_flags, 8'h00, "clear bit 4")
		persistence_setting <= 4'h0;
		conv(16'h0096, 16'h0000);
		`CHECK(event_flags[4], 1'b1, "every conversion")
		wr(EVENT_FLAGS_OFS, 8'h10);
		persistence_setting <= 4'h1;
		conv(16'h00C8, 16'h0000);
		`CHECK(event_flags[4], 1'b0, "equal to high is inside")
		conv(16'h0063, 16'h0000);
		`CHECK(event_flags[4], 1'b1, "below low")
	endtask

	task automatic t_results();
		conv(16'h1234, 16'hABCD);
		rd_chk(VIS_LOW_OFS, 2, 16'h1234, "vis result");
		rd_chk(IR_LOW_OFS, 2, 16'hABCD, "ir result");
		rd_chk(VIS_LOW_OFS, 1, 16'h0034, "vis low alone");
		conv(16'h5678, 16'h9A00);
		rd_chk(VIS_HIGH_OFS, 1, 16'h0012, "high from latched pair");
		rd_chk(IR_LOW_OFS, 2, 16'h9A00, "ir second result");
	endtask

	task automatic t_cor();
		wr(BEHAVIOUR_CFG_OFS, 8'hCC);
		wr(EVENT_FLAGS_OFS, 8'hFF);
		`CHECK(event_flags, 8'h00, "clear all")
		ev(1'b1, 1'b1);
		rd_chk(EVENT_FLAGS_OFS, 1, 16'h0088, "read before clear");
		`CHECK(event_flags, 8'h00, "cleared by read")
		wr(BEHAVIOUR_CFG_OFS, 8'h4C);
		ev(1'b1, 1'b0);
		rd_chk(EVENT_FLAGS_OFS, 1, 16'h0080, "read with option off");
		`CHECK(event_flags, 8'h80, "kept with option off")
	endtask

	// entries: coarse, boost, low select, gain times two
	task automatic t_gain();
		logic [12:0] tbl [6] = '{{2'h0, 2'h0, 9'h001}, {2'h0, 2'h1, 9'h002},
			{2'h1, 2'h1, 9'h008}, {2'h2, 2'h1, 9'h020}, {2'h3, 2'h1, 9'h080},
			{2'h3, 2'h3, 9'h100}};
		for (int i = 0; i < 6; i++)
		begin
			@(posedge sys_clk);
			coarse_gain_field <= tbl[i][12:11];
			wr(GAIN_EXT_OFS, {3'h7, tbl[i][10], 1'h1, tbl[i][9], 2'h3});
			repeat (4) @(posedge sys_clk);
			`CHECK(overall_gain_x2, tbl[i][8:0], "overall gain")
			`CHECK({gain_boost_bit, gain_low_select_bit}, tbl[i][10:9], "gain bits")
			rd_chk(GAIN_EXT_OFS, 1, {11'h000, tbl[i][10], 1'h0, tbl[i][9], 2'h0}, "gain reg");
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		arst_n = 1'b0;
		conv_valid = 1'b0;
		vis_raw = 16'h0000;
		ir_raw = 16'h0000;
		thresh_low = 16'h0000;
		thresh_high = 16'hFFFF;
		persistence_setting = 4'h0;
		coarse_gain_field = 2'h0;
		saturation_event = 1'b0;
		calibration_done_event = 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_ids();
		t_flags();
		t_threshold();
		t_results();
		t_cor();
		t_gain();
		report_and_stop();
	end

	// the sequence needs roughly 24000 cycles
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		n_errors++;
		report_and_stop();
	end
endmodule
